// file: sarseq_defines.svh
`ifndef SARSEQ_DEFINES_SVH
`define SARSEQ_DEFINES_SVH

// ----------------------------------------
// Converter geometry and codes
// ----------------------------------------
`define SARSEQ_BITS 16
`define SARSEQ_MSB_INDEX 4'hF
`define SARSEQ_CODE_ZERO 16'h0000
`define SARSEQ_CODE_FULL 16'hFFFF
`define SARSEQ_CODE_MID 16'h8000

// ----------------------------------------
// Timing (clock 200 MHz)
// ----------------------------------------
`define SARSEQ_CLK_MHZ 200
// Settling after opening the ground switches, in ns.
`define SARSEQ_OPEN_NS 10
`define SARSEQ_OPEN_CYC ((`SARSEQ_OPEN_NS * `SARSEQ_CLK_MHZ + 999) / 1000)
// Comparator settling per search step, in ns.
`define SARSEQ_STEP_NS 20
`define SARSEQ_STEP_CYC ((`SARSEQ_STEP_NS * `SARSEQ_CLK_MHZ + 999) / 1000)
// Shortest time back in acquisition before a new start is honoured, in ns.
`define SARSEQ_ACQ_NS 100
`define SARSEQ_ACQ_CYC ((`SARSEQ_ACQ_NS * `SARSEQ_CLK_MHZ + 999) / 1000)

`endif

// file: sarseq_pkg.sv
package sarseq_pkg;

	// ----------------------------------------
	// Sequencer phases
	// ----------------------------------------
	typedef enum logic [2:0] {
		SARSEQ_ACQUIRE,
		SARSEQ_OPEN_GND,
		SARSEQ_HOLD,
		SARSEQ_SEARCH,
		SARSEQ_DONE
	} sarseq_state_e;

	typedef logic [15:0] sarseq_code_t;

endpackage : sarseq_pkg

// file: sarseq_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
`include "sarseq_defines.svh"

// ----------------------------------------
// Three-stage pin synchroniser with agreement filter
// ----------------------------------------
module sarseq_pin_sync (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic pin,
	output logic level,
	output logic rise
);

	logic s1_ff;
	logic s2_ff;
	logic s3_ff;
	logic level_ff;
	logic agree;
	logic nxt_level;

	// Only the second and third stages are compared; the first is metastability guard.
	assign agree = (s2_ff == s3_ff);
	assign nxt_level = agree ? s3_ff : level_ff;
	assign level = level_ff;
	assign rise = agree && s3_ff && !level_ff;

	// Shift chain and filtered level.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s1_ff <= 1'b0;
			s2_ff <= 1'b0;
			s3_ff <= 1'b0;
			level_ff <= 1'b0;
		end else begin
			s1_ff <= pin;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			level_ff <= nxt_level;
		end
	end

endmodule : sarseq_pin_sync
`default_nettype wire

// file: sarseq_wait_timer.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Small reloadable down-counter
// ----------------------------------------
module sarseq_wait_timer (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic load,
	input wire logic [7:0] count,
	output logic expired
);

	logic [7:0] cnt_ff;
	logic [7:0] nxt_cnt;

	// Load with the count; expired once it reaches zero.
	assign nxt_cnt = load ? count : ((cnt_ff != 8'h00) ? cnt_ff - 8'h01 : 8'h00);
	// Expired looks at the register only; the load is decided from expired, so gating it would close a loop.
	assign expired = (cnt_ff == 8'h00);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_ff <= 8'h00;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end

endmodule : sarseq_wait_timer
`default_nettype wire

// file: sarseq_sequencer.sv
// Functional notes
// R1: Start only on rising edge after acquisition.
// R2: Acquire: ground switches closed, arrays on inputs.
// R3: Open ground switches, then arrays to ground.
// R4: Sixteen-step binary search, MSB first.
// R5: Keep bit if comparator not exceeded.
// R6: After search: acquire, output code, busy pulse.
// R7: Sequence from own clock, no serial clock.
// R8: Result belongs to its own conversion start.
// R9: Power down between conversions, 1 MSPS capable.
// R10: Straight unsigned binary output code.
// R11: Overrange gives FFFF, underrange gives 0000.
// R12: Started conversion ignores later start levels.
`timescale 1ns/1ps
`default_nettype none
`include "sarseq_defines.svh"

module sarseq_sequencer
	import sarseq_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic convert_start,
	input wire logic comp_exceeded,
	output logic pos_array_ground_switch,
	output logic neg_array_ground_switch,
	output logic arrays_on_inputs,
	output logic [15:0] element_on_ref,
	output logic converter_powered,
	output logic busy,
	output logic done_pulse,
	output logic [15:0] result
);

	// ----------------------------------------
	// Start edge from the pin
	// ----------------------------------------
	logic start_rise;

	sarseq_pin_sync u_start_sync (
		.clk(clk),
		.reset_n(reset_n),
		.pin(convert_start),
		.level(),
		.rise(start_rise)
	);

	// ----------------------------------------
	// State and datapath registers
	// ----------------------------------------
	sarseq_state_e state_ff;
	sarseq_state_e nxt_state;
	logic [3:0] bit_ff;
	logic [3:0] nxt_bit;
	logic [15:0] trial_ff;
	logic [15:0] nxt_trial;
	sarseq_code_t result_ff;
	sarseq_code_t nxt_result;
	logic done_ff;
	logic timer_load;
	logic [7:0] timer_count;
	logic timer_expired;

	sarseq_wait_timer u_timer (
		.clk(clk),
		.reset_n(reset_n),
		.load(timer_load),
		.count(timer_count),
		.expired(timer_expired)
	);

	// ----------------------------------------
	// Decode of phases and the trial bit
	// ----------------------------------------
	logic in_acquire;
	logic acq_ready;
	logic step_done;
	logic last_step;
	logic [15:0] bit_mask;
	logic [15:0] decided;

	assign in_acquire = (state_ff == SARSEQ_ACQUIRE);
	// Acquisition is complete only once the minimum tracking time has passed. [R1]
	assign acq_ready = in_acquire && timer_expired;
	assign step_done = (state_ff == SARSEQ_SEARCH) && timer_expired;
	assign last_step = (bit_ff == 4'h0);
	assign bit_mask = 16'h0001 << bit_ff;
	// Keep the element on reference only when the comparator is not exceeded. [R5]
	assign decided = comp_exceeded ? (trial_ff & ~bit_mask) : trial_ff;

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	// The start pin is read only in acquisition, so later levels cannot abort. [R12]
	always_comb begin
		nxt_state = state_ff;
		nxt_bit = bit_ff;
		nxt_trial = trial_ff;
		nxt_result = result_ff;
		timer_load = 1'b0;
		timer_count = 8'h00;
		case (state_ff)
			SARSEQ_ACQUIRE: begin
				if (acq_ready && start_rise) begin // [R1]
					nxt_state = SARSEQ_OPEN_GND;
					timer_load = 1'b1;
					timer_count = 8'(`SARSEQ_OPEN_CYC);
				end
			end
			SARSEQ_OPEN_GND: begin
				// Ground switches open first, arrays move only after the gap. [R3]
				if (timer_expired) begin
					nxt_state = SARSEQ_HOLD;
				end
			end
			SARSEQ_HOLD: begin
				// Arrays are now on ground; load MSB trial. [R4]
				nxt_state = SARSEQ_SEARCH;
				nxt_bit = `SARSEQ_MSB_INDEX;
				nxt_trial = `SARSEQ_CODE_MID;
				timer_load = 1'b1;
				timer_count = 8'(`SARSEQ_STEP_CYC);
			end
			SARSEQ_SEARCH: begin
				if (step_done) begin
					if (last_step) begin
						nxt_state = SARSEQ_DONE;
						nxt_trial = decided;
					end else begin
						nxt_bit = bit_ff - 4'h1;
						nxt_trial = decided | (bit_mask >> 1);
						timer_load = 1'b1;
						timer_count = 8'(`SARSEQ_STEP_CYC);
					end
				end
			end
			SARSEQ_DONE: begin
				// Saturation falls out of the search: all keeps give FFFF, none give 0000. [R11]
				nxt_result = trial_ff; // [R6] [R8] [R10]
				nxt_state = SARSEQ_ACQUIRE;
				timer_load = 1'b1;
				timer_count = 8'(`SARSEQ_ACQ_CYC);
			end
			default: begin
				nxt_state = SARSEQ_ACQUIRE;
			end
		endcase
	end

	// ----------------------------------------
	// Registers, all on the internal clock only
	// ----------------------------------------
	// No serial clock enters here; steps are paced by the local timer. [R7]
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_ff <= SARSEQ_ACQUIRE;
			bit_ff <= 4'h0;
			trial_ff <= 16'h0000;
			result_ff <= `SARSEQ_CODE_ZERO;
			done_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			bit_ff <= nxt_bit;
			trial_ff <= nxt_trial;
			result_ff <= nxt_result;
			done_ff <= (state_ff == SARSEQ_DONE);
		end
	end

	// ----------------------------------------
	// Switch drive and status
	// ----------------------------------------
	// Acquire: ground switches closed and arrays on the inputs. [R2]
	assign pos_array_ground_switch = in_acquire;
	assign neg_array_ground_switch = in_acquire;
	// Arrays leave the inputs only after the open-ground phase. [R3]
	assign arrays_on_inputs = in_acquire || (state_ff == SARSEQ_OPEN_GND);
	assign element_on_ref = (state_ff == SARSEQ_SEARCH) ? trial_ff : 16'h0000; // [R4]
	// Comparator and array drivers sleep in acquisition, saving power. [R9]
	assign converter_powered = !in_acquire;
	assign busy = !in_acquire;
	assign done_pulse = done_ff; // [R6]
	assign result = result_ff;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_start_needs_edge;
		@(posedge clk) disable iff (!reset_n)
		in_acquire && !(acq_ready && start_rise) |=> in_acquire;
	endproperty
	a_start_needs_edge: assert property (p_start_needs_edge) else $error("Conversion began without start edge."); // [R1]

	property p_acq_switches;
		@(posedge clk) disable iff (!reset_n)
		in_acquire |-> pos_array_ground_switch && neg_array_ground_switch && arrays_on_inputs;
	endproperty
	a_acq_switches: assert property (p_acq_switches) else $error("Acquisition switch setup wrong."); // [R2]

	property p_open_before_move;
		@(posedge clk) disable iff (!reset_n)
		$fell(arrays_on_inputs) |-> $past(!pos_array_ground_switch) && !neg_array_ground_switch;
	endproperty
	a_open_before_move: assert property (p_open_before_move) else $error("Arrays moved before ground opened."); // [R3]

	property p_msb_first;
		@(posedge clk) disable iff (!reset_n)
		state_ff == SARSEQ_HOLD |=> element_on_ref == 16'h8000 && bit_ff == 4'hF;
	endproperty
	a_msb_first: assert property (p_msb_first) else $error("Search did not start at MSB."); // [R4]

	property p_drop_exceeded;
		@(posedge clk) disable iff (!reset_n)
		step_done && comp_exceeded && !last_step |=> (trial_ff & ($past(bit_mask))) == 16'h0000;
	endproperty
	a_drop_exceeded: assert property (p_drop_exceeded) else $error("Exceeded bit was kept."); // [R5]

	property p_done_returns;
		@(posedge clk) disable iff (!reset_n)
		state_ff == SARSEQ_DONE |=> in_acquire && done_pulse && result == $past(trial_ff);
	endproperty
	a_done_returns: assert property (p_done_returns) else $error("Completion sequence wrong."); // [R6]

	property p_ignore_start;
		@(posedge clk) disable iff (!reset_n)
		state_ff == SARSEQ_SEARCH && !step_done |=> state_ff == SARSEQ_SEARCH;
	endproperty
	a_ignore_start: assert property (p_ignore_start) else $error("Conversion aborted early."); // [R12]

	property p_power_down;
		@(posedge clk) disable iff (!reset_n)
		in_acquire |-> !converter_powered && element_on_ref == 16'h0000;
	endproperty
	a_power_down: assert property (p_power_down) else $error("Powered during acquisition."); // [R9]

	// ----------------------------------------
	// Sequence and timing checks
	// ----------------------------------------
	property p_acq_window;
		@(posedge clk) disable iff (!reset_n)
		in_acquire && !timer_expired |=> in_acquire;
	endproperty
	a_acq_window: assert property (p_acq_window) else $error("Start honoured before acquisition ended."); // [R1]

	property p_open_gap;
		@(posedge clk) disable iff (!reset_n)
		state_ff == SARSEQ_OPEN_GND |-> !pos_array_ground_switch && !neg_array_ground_switch && arrays_on_inputs;
	endproperty
	a_open_gap: assert property (p_open_gap) else $error("Open-ground phase switch setup wrong."); // [R3]

	// The gap is three cycles with the open count of two; retune this if that count changes.
	property p_open_len;
		@(posedge clk) disable iff (!reset_n)
		$rose(busy) |-> arrays_on_inputs [*3] ##1 !arrays_on_inputs;
	endproperty
	a_open_len: assert property (p_open_len) else $error("Arrays left inputs at the wrong time."); // [R3]

	// Sixteen steps of five cycles each, plus the hold cycle.
	property p_search_len;
		@(posedge clk) disable iff (!reset_n)
		$fell(arrays_on_inputs) |-> ##81 state_ff == SARSEQ_DONE;
	endproperty
	a_search_len: assert property (p_search_len) else $error("Search did not take sixteen steps."); // [R4]

	property p_keep_fit;
		@(posedge clk) disable iff (!reset_n)
		step_done && !comp_exceeded |=> (trial_ff & $past(bit_mask)) != 16'h0000;
	endproperty
	a_keep_fit: assert property (p_keep_fit) else $error("Fitting bit was dropped."); // [R5]

	property p_one_done;
		@(posedge clk) disable iff (!reset_n)
		done_pulse |=> !done_pulse;
	endproperty
	a_one_done: assert property (p_one_done) else $error("Completion pulse longer than one cycle."); // [R6]

	property p_busy_ends;
		@(posedge clk) disable iff (!reset_n)
		$fell(busy) |-> done_pulse && in_acquire;
	endproperty
	a_busy_ends: assert property (p_busy_ends) else $error("Busy ended without completion."); // [R6]

	property p_step_pace;
		@(posedge clk) disable iff (!reset_n)
		state_ff == SARSEQ_HOLD |=> !step_done [*4] ##1 step_done;
	endproperty
	a_step_pace: assert property (p_step_pace) else $error("Step not paced by the local timer."); // [R7]

	property p_result_holds;
		@(posedge clk) disable iff (!reset_n)
		!done_pulse |-> $stable(result);
	endproperty
	a_result_holds: assert property (p_result_holds) else $error("Result changed outside completion."); // [R8]

	property p_start_refused;
		@(posedge clk) disable iff (!reset_n)
		(state_ff == SARSEQ_SEARCH || state_ff == SARSEQ_DONE) && start_rise |=> state_ff != SARSEQ_OPEN_GND;
	endproperty
	a_start_refused: assert property (p_start_refused) else $error("Start edge restarted a conversion."); // [R12]

	c_start: cover property (@(posedge clk) disable iff (!reset_n) start_rise && acq_ready);
	c_full: cover property (@(posedge clk) disable iff (!reset_n) done_pulse && result == 16'hFFFF);
	c_zero: cover property (@(posedge clk) disable iff (!reset_n) done_pulse && result == 16'h0000);
	c_early: cover property (@(posedge clk) disable iff (!reset_n) in_acquire && !timer_expired && start_rise);
	c_refused: cover property (@(posedge clk) disable iff (!reset_n) state_ff == SARSEQ_SEARCH && start_rise);

endmodule : sarseq_sequencer
`default_nettype wire

// file: sarseq_comp_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Comparator and capacitor array model
// ----------------------------------------
module sarseq_comp_model (
	input wire logic clk,
	input wire logic arrays_on_inputs,
	input wire logic [15:0] element_on_ref,
	input wire logic signed [17:0] vin,
	output logic comp_exceeded
);
	logic signed [17:0] held_ff;

	// The level is tracked only while the arrays sit on the inputs, so later moves are ignored.
	always_ff @(posedge clk) begin
		if (arrays_on_inputs) begin
			held_ff <= vin;
		end
	end

	// Out-of-span levels make the comparator always or never trip, which saturates the code.
	assign comp_exceeded = $signed({2'b00, element_on_ref}) > held_ff;
endmodule : sarseq_comp_model
`default_nettype wire

// file: test_sar_conversion_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; $display("BAD %0t got %h", $time, a); end end

module test_sar_conversion_sequencer;
	import sarseq_pkg::*;
	logic clk, reset_n, convert_start, comp_exceeded, pos_sw, neg_sw, on_inputs, powered, busy, done_pulse;
	logic [15:0] on_ref, result;
	logic signed [17:0] vin;
	int checked = 0;
	int num_errors = 0;
	int cycles = 0;
	logic signed [17:0] vins [9] = '{18'h00000, 18'h00001, 18'h07FFF, 18'h08000, 18'h08001,
		18'h05A3C, 18'h0FFFF, 18'h10005, 18'h3FFFD};
	logic [15:0] exps [9] = '{16'h0000, 16'h0001, 16'h7FFF, 16'h8000, 16'h8001,
		16'h5A3C, 16'hFFFF, 16'hFFFF, 16'h0000};

	sarseq_sequencer sarseq_sequencer_i (.clk(clk), .reset_n(reset_n), .convert_start(convert_start),
		.comp_exceeded(comp_exceeded), .pos_array_ground_switch(pos_sw), .neg_array_ground_switch(neg_sw),
		.arrays_on_inputs(on_inputs), .element_on_ref(on_ref), .converter_powered(powered), .busy(busy),
		.done_pulse(done_pulse), .result(result));
	sarseq_comp_model sarseq_comp_model_i (.clk(clk), .arrays_on_inputs(on_inputs), .element_on_ref(on_ref),
		.vin(vin), .comp_exceeded(comp_exceeded));

	// ----------------------------------------
	// Clock and hang guard
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// A run of about 1350 cycles is expected, so this ceiling only trips on a hang.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			complete_run();
		end
	end

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	// One conversion with a refused start in mid-search and an optional early start after it.
	task automatic convert(input logic signed [17:0] v, input logic [15:0] exp, input bit early);
		int n;
		n = 0;
		vin = v;
		convert_start = 1'b1;
		while (busy !== 1'b1 && n < 20) begin
			@(negedge clk);
			n++;
		end
		`CHK({busy, powered}, 2'b11)
		`CHK({pos_sw, neg_sw, on_inputs}, 3'b001)
		while (on_ref === 16'h0000 && n < 40) begin
			@(negedge clk);
			n++;
		end
		`CHK({on_inputs, on_ref}, {1'b0, 16'h8000})
		convert_start = 1'b0;
		vin = ~v;
		repeat (20) @(negedge clk);
		n += 20;
		convert_start = 1'b1;
		while (done_pulse !== 1'b1 && n < 300) begin
			@(negedge clk);
			n++;
		end
		`CHK(result, exp)
		`CHK(n < 180, 1'b1)
		`CHK({busy, powered, pos_sw, neg_sw, on_inputs, on_ref}, {5'b00111, 16'h0000})
		@(negedge clk);
		`CHK(done_pulse, 1'b0)
		if (early) begin
			convert_start = 1'b0;
			repeat (3) @(negedge clk);
			convert_start = 1'b1;
		end
		repeat (30) @(negedge clk);
		`CHK(busy, 1'b0)
		convert_start = 1'b0;
		repeat (25) @(negedge clk);
	endtask : convert

	// Prints the counts and the verdict, then ends the run.
	task automatic complete_run();
		$display("checks %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : complete_run

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		reset_n = 1'b0;
		convert_start = 1'b0;
		vin = 18'h00000;
		repeat (12) @(negedge clk);
		`CHK({busy, done_pulse, pos_sw, neg_sw, on_inputs, result}, {5'b00111, 16'h0000})
		reset_n = 1'b1;
		repeat (4) @(negedge clk);
		for (int i = 0; i < 9; i++) begin
			convert(vins[i], exps[i], i[0]);
		end
		complete_run();
	end
endmodule : test_sar_conversion_sequencer
`default_nettype wire
